// >>> pkg/dcf_defs.vh
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH
// apb register byte addresses
`define DCF_ADDR_CTRL      12'h000
`define DCF_ADDR_DATA      12'h004
`define DCF_ADDR_STATUS    12'h008
`define DCF_ADDR_CFG       12'h00C
`define DCF_ADDR_RETRY     12'h010
`define DCF_ADDR_IRQ_STAT  12'h014
`define DCF_ADDR_IRQ_MASK  12'h018
`define DCF_ADDR_CMD       12'h01C
`define DCF_ADDR_ERRSTAT   12'h020
// data field layout
`define DCF_KEY_LAST       9'd31
`define DCF_BYTE_CACHE     9'd32
`define DCF_BYTE_RECOV     9'd36
`define DCF_BYTE_RETRY     9'd37
`define DCF_BYTE_SPAN      9'd38
`define DCF_BYTE_DRIVE     9'd39
`define DCF_FIELD_LAST     9'd511
`define DCF_CE_BIT         0
`define DCF_PE_BIT         1
`define DCF_DCR_BIT        0
`define DCF_EEC_BIT        3
`define DCF_RC_BIT         4
`define DCF_ARR_BIT        6
`define DCF_WRITE_REALLOC_ENABLE_BIT       7
`define DCF_UNCORRECTABLE_REALLOC_ENABLE_BIT       1
`define DCF_WCE_BIT        2
// reset values and fixed constants
`define DCF_RST_RETRY      8'h08
`define DCF_FIXED_SPAN     8'h18
`define DCF_ASCII_SPACE    8'h20
// command classes for error reporting
`define DCF_CMD_GENERIC    3'h0
`define DCF_CMD_READ       3'h1
`define DCF_CMD_WRITE      3'h2
`define DCF_CMD_DIAG       3'h3
`define DCF_CMD_INITP      3'h4
`define DCF_CMD_SETCFG     3'h5
`endif

// >>> rtl/dcf_top.v
`timescale 1ns/1ps
`include "dcf_defs.vh"
module dcf_top #(
   parameter [255:0] KEY_SIG = {"CONFIGURATION", 8'h20, "ABCDEFG", {11{8'h20}}} // arbitrary value
) (
   // clock and reset
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // decoded policy
   output reg         cache_on_o,
   output reg         prefetch_on_o,
   output reg         write_realloc_o,
   output reg         read_realloc_o,
   output reg         uncorr_realloc_o,
   output reg         early_corrected_flag_o,
   output reg         corrected_flag_disable_o,
   output reg         continuous_read_o,
   output reg  [7:0]  reread_count_o,
   output reg  [7:0]  corrected_flag_span_o,
   output reg         write_cache_o,
   output reg         flush_keep_o,
   // interrupt
   output reg         irq_o
);
   localparam S_IDLE = 3'b001;
   localparam S_RECV = 3'b010;
   localparam S_DONE = 3'b100;

   // expected key byte for a field index
   function [7:0] key_byte;
      input [8:0] idx;
      begin
         key_byte = KEY_SIG[8'd255 - {idx[4:0], 3'b000} -: 8];
      end
   endfunction

   // valid error mask {bbk,unc,id_missing_flag,aborted_flag,tko,address_mark_missing_flag} per command class
   function [5:0] err_valid;
      input [2:0] cls;
      begin
         case (cls)
            `DCF_CMD_READ:   err_valid = 6'b111101;
            `DCF_CMD_WRITE:  err_valid = 6'b101100;
            `DCF_CMD_SETCFG: err_valid = 6'b101100;
            `DCF_CMD_DIAG:   err_valid = 6'b000000;
            `DCF_CMD_INITP:  err_valid = 6'b000000;
            default:         err_valid = 6'b000100;
         endcase
      end
   endfunction

   reg  [2:0]  state_q;
   reg  [8:0]  idx_q;
   reg         key_bad_q;
   // live configuration flags
   reg         ce_q;
   reg         pe_q;
   reg         write_realloc_enable_q;
   reg         arr_q;
   reg         rc_q;
   reg         eec_q;
   reg         dcr_q;
   reg         wce_q;
   reg         uncorrectable_realloc_enable_q;
   reg  [7:0]  retry_q;
   // staged copies filled while the field streams in
   reg         n_ce_q;
   reg         n_pe_q;
   reg         n_write_realloc_enable_q;
   reg         n_arr_q;
   reg         n_rc_q;
   reg         n_eec_q;
   reg         n_dcr_q;
   reg         n_wce_q;
   reg         n_uncorrectable_realloc_enable_q;
   reg  [7:0]  n_retry_q;
   // interrupt and command report state
   reg  [2:0]  irq_stat_q;
   reg  [2:0]  irq_mask_q;
   reg  [2:0]  cmd_cls_q;
   reg         prev_write_q;
   reg  [6:0]  err_q;
   reg         summary_q;
   reg  [31:0] rd_d;

   wire        acc      = psel_i & penable_i & ~pready_o;
   wire        wr       = acc & pwrite_i;
   wire        rd       = acc & ~pwrite_i;
   wire        a_ctrl   = paddr_i == `DCF_ADDR_CTRL;
   wire        a_data   = paddr_i == `DCF_ADDR_DATA;
   wire        a_stat   = paddr_i == `DCF_ADDR_STATUS;
   wire        a_cfg    = paddr_i == `DCF_ADDR_CFG;
   wire        a_retry  = paddr_i == `DCF_ADDR_RETRY;
   wire        a_istat  = paddr_i == `DCF_ADDR_IRQ_STAT;
   wire        a_imask  = paddr_i == `DCF_ADDR_IRQ_MASK;
   wire        a_cmd    = paddr_i == `DCF_ADDR_CMD;
   wire        a_err    = paddr_i == `DCF_ADDR_ERRSTAT;
   wire        mapped   = a_ctrl | a_data | a_stat | a_cfg | a_retry | a_istat | a_imask | a_cmd | a_err;
   wire        byte_wr  = wr & a_data & (state_q == S_RECV);
   wire [7:0]  db       = pwdata_i[7:0];
   wire        start    = wr & a_ctrl & pwdata_i[0];
   wire        last     = byte_wr & (idx_q == `DCF_FIELD_LAST);
   // key mismatch of the last key byte counts too
   wire        key_miss = byte_wr & (idx_q <= `DCF_KEY_LAST) & (db != key_byte(idx_q));
   wire        bad_now  = key_bad_q | key_miss;
   wire        ev_ok    = last & ~bad_now;
   wire        ev_abort = last & bad_now;
   // command launch with its error report; abort raised before execution
   wire        cmd_go   = wr & a_cmd;
   wire [5:0]  cmd_raw  = pwdata_i[13:8];
   // abort outranks all later errors: execution never started
   wire [5:0]  cmd_err  = (cmd_raw[2] ? 6'b000100 : cmd_raw) & err_valid(pwdata_i[2:0]);

   // command class decode, shared by the report logic
   wire [2:0]  cmd_cls  = pwdata_i[2:0];
   wire        is_read  = cmd_cls == `DCF_CMD_READ;
   wire        is_write = cmd_cls == `DCF_CMD_WRITE;
   wire        is_diag  = cmd_cls == `DCF_CMD_DIAG;
   wire        is_initp = cmd_cls == `DCF_CMD_INITP;
   // continuous read swallows read errors; summary and interrupt must agree with that
   wire        rc_hide  = rc_q & is_read;
   wire [5:0]  err_rep  = rc_hide ? 6'h00 : cmd_err;

   // sticky event sources and software clear
   wire [2:0]  irq_clr  = (wr & a_istat) ? pwdata_i[2:0] : 3'h0;
   wire [2:0]  irq_set  = {cmd_go & (|err_rep), ev_abort, ev_ok};

   // field receive sequencer
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q   <= S_IDLE;
         idx_q     <= 9'h000;
         key_bad_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q   <= S_RECV;
                  idx_q     <= 9'h000;
                  key_bad_q <= 1'b0;
               end
            end
            S_RECV: begin
               if (byte_wr) begin
                  key_bad_q <= bad_now;
                  idx_q     <= idx_q + 9'h001;
                  if (last)
                     state_q <= S_DONE;
               end
            end
            S_DONE: begin
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // staging copies; live settings change only when the whole field passes
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         n_ce_q    <= 1'b1;
         n_pe_q    <= 1'b1;
         n_write_realloc_enable_q  <= 1'b1;
         n_arr_q   <= 1'b1;
         n_rc_q    <= 1'b0;
         n_eec_q   <= 1'b1;
         n_dcr_q   <= 1'b0;
         n_wce_q   <= 1'b1;
         n_uncorrectable_realloc_enable_q  <= 1'b1;
         n_retry_q <= `DCF_RST_RETRY;
      end else if (byte_wr) begin
         // bytes 40..511 are ignored, the host is expected to zero them
         case (idx_q)
            `DCF_BYTE_CACHE: begin
               n_ce_q <= db[`DCF_CE_BIT];
               n_pe_q <= db[`DCF_PE_BIT];
            end
            `DCF_BYTE_RECOV: begin
               n_write_realloc_enable_q <= db[`DCF_WRITE_REALLOC_ENABLE_BIT];
               n_arr_q  <= db[`DCF_ARR_BIT];
               n_rc_q   <= db[`DCF_RC_BIT];
               n_eec_q  <= db[`DCF_EEC_BIT];
               n_dcr_q  <= db[`DCF_DCR_BIT];
            end
            `DCF_BYTE_RETRY: n_retry_q <= db;
            `DCF_BYTE_DRIVE: begin
               n_wce_q  <= db[`DCF_WCE_BIT];
               n_uncorrectable_realloc_enable_q <= db[`DCF_UNCORRECTABLE_REALLOC_ENABLE_BIT];
            end
            default: n_retry_q <= n_retry_q;
         endcase
      end
   end

   // live configuration, reset to defaults
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ce_q    <= 1'b1;
         pe_q    <= 1'b1;
         write_realloc_enable_q  <= 1'b1;
         arr_q   <= 1'b1;
         rc_q    <= 1'b0;
         eec_q   <= 1'b1;
         dcr_q   <= 1'b0;
         wce_q   <= 1'b1;
         uncorrectable_realloc_enable_q  <= 1'b1;
         retry_q <= `DCF_RST_RETRY;
      end else if (ev_ok) begin
         // a half-written or aborted field never reaches the live copy
         ce_q    <= n_ce_q;
         pe_q    <= n_pe_q;
         write_realloc_enable_q  <= n_write_realloc_enable_q;
         arr_q   <= n_arr_q;
         rc_q    <= n_rc_q;
         eec_q   <= n_eec_q;
         dcr_q   <= n_dcr_q;
         wce_q   <= n_wce_q;
         uncorrectable_realloc_enable_q  <= n_uncorrectable_realloc_enable_q;
         retry_q <= n_retry_q;
      end
   end

   // decoded policy outputs with override rules
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cache_on_o        <= 1'b1;
         prefetch_on_o     <= 1'b1;
         write_realloc_o   <= 1'b1;
         read_realloc_o    <= 1'b1;
         uncorr_realloc_o  <= 1'b1;
         early_corrected_flag_o      <= 1'b1;
         corrected_flag_disable_o    <= 1'b0;
         continuous_read_o <= 1'b0;
         // early correction is on by default, so no rereads are scheduled
         reread_count_o    <= 8'h00;
         corrected_flag_span_o       <= `DCF_FIXED_SPAN;
         write_cache_o     <= 1'b1;
         flush_keep_o      <= 1'b0;
      end else begin
         cache_on_o        <= ce_q;
         prefetch_on_o     <= ce_q & pe_q;
         write_realloc_o   <= write_realloc_enable_q;
         read_realloc_o    <= arr_q & ~rc_q;
         uncorr_realloc_o  <= uncorrectable_realloc_enable_q & arr_q & ~rc_q;
         early_corrected_flag_o      <= eec_q & ~rc_q;
         corrected_flag_disable_o    <= dcr_q & ~rc_q;
         continuous_read_o <= rc_q;
         // rereads are skipped in continuous or early-correction mode
         reread_count_o    <= (rc_q | eec_q) ? 8'h00 : retry_q;
         corrected_flag_span_o       <= `DCF_FIXED_SPAN;
         write_cache_o     <= wce_q;
         // cached flush continues only when a write follows a write
         flush_keep_o      <= wce_q & prev_write_q;
      end
   end

   // command class tracking and error/status report
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmd_cls_q    <= `DCF_CMD_GENERIC;
         prev_write_q <= 1'b0;
         err_q        <= 7'h00;
         summary_q    <= 1'b0;
      end else if (cmd_go) begin
         cmd_cls_q    <= cmd_cls;
         prev_write_q <= is_write & (cmd_cls_q == `DCF_CMD_WRITE);
         // continuous read hides errors it chose to ignore
         err_q[5:0]   <= err_rep;
         // corrected status is read-only, never on writes
         err_q[6]     <= pwdata_i[16] & is_read & ~rc_q;
         // summary follows the reported bits except for diag, which takes pwdata_i[17]; hidden errors leave it clear
         summary_q    <= is_initp ? 1'b0 :
                         is_diag ? pwdata_i[17] : (|err_rep);
      end else if (ev_abort) begin
         err_q     <= 7'h04;
         summary_q <= 1'b1;
      end
   end

   // sticky events: set wins over write-one-to-clear
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
      end else begin
         // an event in the clearing cycle survives the clear
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (wr & a_imask)
            irq_mask_q <= pwdata_i[2:0];
      end
   end

   // read mux
   always @* begin
      rd_d = 32'h0000_0000;
      case (1'b1)
         a_stat:   rd_d = {22'h00_0000, idx_q, state_q == S_RECV ? 1'b1 : 1'b0};
         a_cfg:    rd_d = {16'h0000, 7'h00, wce_q, uncorrectable_realloc_enable_q, write_realloc_enable_q, arr_q, rc_q, eec_q, dcr_q, pe_q, ce_q};
         a_retry:  rd_d = {16'h0000, corrected_flag_span_o, retry_q};
         a_istat:  rd_d = {29'h0000_0000, irq_stat_q};
         a_imask:  rd_d = {29'h0000_0000, irq_mask_q};
         a_err:    rd_d = {23'h00_0000, summary_q, 1'b0, err_q};
         default:  rd_d = 32'h0000_0000;
      endcase
   end

   // apb handshake: one wait state, pready registered from the access phase
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         irq_o     <= 1'b0;
      end else begin
         pready_o  <= acc;
         pslverr_o <= acc & ~mapped;
         prdata_o  <= rd ? rd_d : 32'h0000_0000;
         irq_o     <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule

// >>> tb/dcf_top_assertions.sv
`timescale 1ns/1ps
`include "dcf_defs.vh"
module dcf_checker (
   // clock, reset and bus request
   input wire logic        sys_clk_i,
   input wire logic        nrst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   // decoded policy and interrupt
   input wire logic        cache_on_o,
   input wire logic        prefetch_on_o,
   input wire logic        write_realloc_o,
   input wire logic        read_realloc_o,
   input wire logic        uncorr_realloc_o,
   input wire logic        early_corrected_flag_o,
   input wire logic        corrected_flag_disable_o,
   input wire logic        continuous_read_o,
   input wire logic [7:0]  reread_count_o,
   input wire logic [7:0]  corrected_flag_span_o,
   input wire logic        write_cache_o,
   input wire logic        flush_keep_o,
   input wire logic        irq_o
);
   // one clock domain, so clock and reset are given once
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // policy relations that must hold in every cycle
   property p_pf_gate; prefetch_on_o |-> cache_on_o; endproperty
   property p_rc_mask; continuous_read_o |-> !(read_realloc_o || early_corrected_flag_o || corrected_flag_disable_o); endproperty
   property p_unc; uncorr_realloc_o |-> read_realloc_o; endproperty
   property p_span; corrected_flag_span_o == 8'h18; endproperty
   property p_reread; (continuous_read_o || early_corrected_flag_o) |-> reread_count_o == 8'h00; endproperty
   property p_flush; flush_keep_o |-> write_cache_o; endproperty
   // defaults must be present at the first edge after release
   property p_dflt;
      $rose(nrst_i) |-> cache_on_o && prefetch_on_o && write_realloc_o && read_realloc_o && uncorr_realloc_o
         && early_corrected_flag_o && write_cache_o && !continuous_read_o && !corrected_flag_disable_o;
   endproperty
   // a write_cache_o change only follows a data byte taken two edges before; reset edges are skipped
   property p_commit;
      $past(nrst_i) && !$stable(write_cache_o) |->
         $past(psel_i && penable_i && pwrite_i && paddr_i == `DCF_ADDR_DATA, 2);
   endproperty
   a_pf_gate: assert property (p_pf_gate) else $error("prefetch without cache");
   a_rc_mask: assert property (p_rc_mask) else $error("continuous read not masking");
   a_unc: assert property (p_unc) else $error("uncorrectable realloc without read realloc");
   a_span: assert property (p_span) else $error("correction span not fixed");
   a_reread: assert property (p_reread) else $error("reread count not zero");
   a_flush: assert property (p_flush) else $error("flush without write cache");
   a_dflt: assert property (p_dflt) else $error("policy not at defaults after reset");
   a_commit: assert property (p_commit) else $error("policy changed without data byte");
   c_irq: cover property ($rose(irq_o));
   c_rc: cover property (continuous_read_o);
   c_flush: cover property (flush_keep_o);
endmodule
bind dcf_top dcf_checker u_chk (.sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .cache_on_o,
   .prefetch_on_o, .write_realloc_o, .read_realloc_o, .uncorr_realloc_o, .early_corrected_flag_o, .corrected_flag_disable_o,
   .continuous_read_o, .reread_count_o, .corrected_flag_span_o, .write_cache_o, .flush_keep_o, .irq_o);

// >>> tb/dcf_host.sv
`timescale 1ns/1ps
`include "dcf_defs.vh"
module dcf_host (
   // clock and slave answer
   input wire logic         sys_clk_i,
   input wire logic         pready_i,
   input wire logic         pslverr_i,
   input wire logic [31:0]  prdata_i,
   // request
   output logic             psel_o = 1'b0,
   output logic             penable_o = 1'b0,
   output logic             pwrite_o = 1'b0,
   output logic [11:0]      paddr_o = 12'h000,
   output logic [31:0]      pwdata_o = 32'h0000_0000
);
   // one transfer; request held until pready is sampled, bounded so a dead slave cannot hang us
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge sys_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= wd;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (!pready_i && n < 64);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, wd, r, e);
   endtask
   // start a field, then one byte per write, key first
   task automatic field(input logic [255:0] key, input logic [7:0] b32, b36, b37, b39);
      logic [7:0] b;
      wr(`DCF_ADDR_CTRL, 32'h0000_0001);
      for (int i = 0; i < 512; i++) begin
         b = (i < 32) ? key[255 - 8 * i -: 8] : 8'h00;
         case (i)
            32: b = b32;
            36: b = b36;
            37: b = b37;
            38: b = 8'h18;
            39: b = b39;
            default: ;
         endcase
         wr(`DCF_ADDR_DATA, {24'h00_0000, b});
      end
   endtask
endmodule

// >>> tb/dcf_top_tb_top.sv
`timescale 1ns/1ps
`include "dcf_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module dcf_top_tb_top;
   localparam [255:0] KEY = {"DRIVESETUP", {22{8'h20}}}; // arbitrary value
   logic        sys_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq, e;
   logic        ce, pe, awr, read_realloc_enable, uar, eec, correction_disable, rc, write_cache_enable, fk;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [7:0]  rr, span;
   int          n_errors = 0;
   int          comparisons = 0;
   logic [31:0] cmd_v [5] = '{32'h0003_3B01, 32'h0003_3B02, 32'h0003_3B03, 32'h0003_3B04, 32'h0003_3B05};
   logic [8:0]  exp_v [5] = '{9'h179, 9'h128, 9'h100, 9'h000, 9'h128};
   // 4 ns period
   always #2 sys_clk_i = ~sys_clk_i;
   dcf_top #(.KEY_SIG(KEY)) u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cache_on_o(ce), .prefetch_on_o(pe), .write_realloc_o(awr), .read_realloc_o(read_realloc_enable),
      .uncorr_realloc_o(uar), .early_corrected_flag_o(eec), .corrected_flag_disable_o(correction_disable), .continuous_read_o(rc),
      .reread_count_o(rr), .corrected_flag_span_o(span), .write_cache_o(write_cache_enable), .flush_keep_o(fk), .irq_o(irq));
   dcf_host u_host (.sys_clk_i(sys_clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog: the run needs about 25 us
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      `CHK({ce, pe, awr, read_realloc_enable, uar, eec, correction_disable, rc, write_cache_enable}, 9'h1f9)
      `CHK(rr, 8'h00)
      `CHK(span, 8'h18)
      u_host.xfer(1'b0, `DCF_ADDR_RETRY, 32'h0, d, e);
      `CHK(d[15:0], 16'h1808)
      u_host.xfer(1'b0, `DCF_ADDR_CFG, 32'h0, d, e);
      `CHK(d[8:0], 9'h1eb)
      // continuous read set together with the flags it overrides
      u_host.field(KEY, 8'h01, 8'h59, 8'h03, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      `CHK({ce, pe, awr, read_realloc_enable, uar, eec, correction_disable, rc, write_cache_enable}, 9'h102)
      `CHK(rr, 8'h00)
      u_host.xfer(1'b0, `DCF_ADDR_IRQ_STAT, 32'h0, d, e);
      `CHK({irq, d[0]}, 2'h1)
      u_host.wr(`DCF_ADDR_IRQ_MASK, 32'h0000_0003);
      repeat (2) @(posedge sys_clk_i);
      `CHK(irq, 1'b1)
      u_host.wr(`DCF_ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge sys_clk_i);
      `CHK(irq, 1'b0)
      u_host.wr(`DCF_ADDR_CMD, 32'h0001_3B01);
      u_host.xfer(1'b0, `DCF_ADDR_ERRSTAT, 32'h0, d, e);
      `CHK(d[8:0], 9'h000)
      // prefetch asked for with cache off, correction disabled, three rereads
      u_host.field(KEY, 8'h02, 8'h01, 8'h03, 8'h06);
      repeat (3) @(posedge sys_clk_i);
      `CHK({ce, pe, awr, read_realloc_enable, uar, eec, correction_disable, rc, write_cache_enable}, 9'h005)
      `CHK(rr, 8'h03)
      // last key byte wrong: command aborted, policy kept
      u_host.field(KEY ^ 256'h1, 8'h01, 8'h40, 8'h05, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      `CHK({ce, pe, awr, read_realloc_enable, uar, eec, correction_disable, rc, write_cache_enable, rr}, {9'h005, 8'h03})
      u_host.xfer(1'b0, `DCF_ADDR_ERRSTAT, 32'h0, d, e);
      `CHK(d[8:0], 9'h104)
      u_host.xfer(1'b0, `DCF_ADDR_IRQ_STAT, 32'h0, d, e);
      `CHK(d[1:0], 2'h3)
      u_host.wr(`DCF_ADDR_IRQ_STAT, 32'h0000_0007);
      // error bits filtered per command class
      for (int i = 0; i < 5; i++) begin
         u_host.wr(`DCF_ADDR_CMD, cmd_v[i]);
         u_host.xfer(1'b0, `DCF_ADDR_ERRSTAT, 32'h0, d, e);
         `CHK(d[8:0], exp_v[i])
      end
      u_host.wr(`DCF_ADDR_CMD, 32'h0000_3F01);
      u_host.xfer(1'b0, `DCF_ADDR_ERRSTAT, 32'h0, d, e);
      `CHK(d[8:0], 9'h104)
      u_host.wr(`DCF_ADDR_CMD, 32'h0000_0002);
      u_host.wr(`DCF_ADDR_CMD, 32'h0000_0002);
      repeat (2) @(posedge sys_clk_i);
      `CHK(fk, 1'b1)
      u_host.xfer(1'b0, 12'h0FC, 32'h0, d, e);
      `CHK(e, 1'b1)
      summarize();
   end
endmodule
